/* rtl/tsp_defs.svh */
// Constants for the touch converter serial port: frame lengths and link timing.
// Assumes a 125 MHz system clock on both ends of the link.
`ifndef TSP_DEFS_SVH
`define TSP_DEFS_SVH

// ----------------------------------------------------------------------------
// Frame layout, counted in serial clock rising edges
// ----------------------------------------------------------------------------
`define TSP_CMD_BITS 5'd8
`define TSP_RD8_END 5'd16
`define TSP_RD16_END 5'd24
`define TSP_CNT_ZERO 5'd0
`define TSP_CNT_ONE 5'd1
`define TSP_RD8_PAD 8'h00
`define TSP_CMD_CLEAR 8'h00
`define TSP_RES_CLEAR 16'h0000
`define TSP_SYNC_HIGH 3'h7
`define TSP_SYNC_LOW 3'h0

// ----------------------------------------------------------------------------
// Link timing, in ns, and derived cycle counts
// ----------------------------------------------------------------------------
`define TSP_SYS_CLK_NS 8
`define TSP_SCLK_PERIOD_NS 80
`define TSP_LEAD_NS 14
`define TSP_LAG_NS 20
`define TSP_SPACE_NS 20
`define TSP_BUSY_GAP_NS 160
`define TSP_NS_TO_CYC(ns) (((ns) + `TSP_SYS_CLK_NS - 1) / `TSP_SYS_CLK_NS)
`define TSP_HALF_CYC 5'(`TSP_NS_TO_CYC(`TSP_SCLK_PERIOD_NS / 2))
`define TSP_LEAD_CYC 5'(`TSP_NS_TO_CYC(`TSP_LEAD_NS))
`define TSP_LAG_CYC 5'(`TSP_NS_TO_CYC(`TSP_LAG_NS))
`define TSP_SPACE_CYC 5'(`TSP_NS_TO_CYC(`TSP_SPACE_NS))
`define TSP_BUSY_GAP_CYC 5'(`TSP_NS_TO_CYC(`TSP_BUSY_GAP_NS))

`endif

/* rtl/tsp_pkg.sv */
// Types shared by both ends of the touch converter serial port.
// Constants live in tsp_defs.svh.
package tsp_pkg;
	typedef enum logic [2:0] {
		TSP_H_IDLE = 3'h0,
		TSP_H_LEAD = 3'h1,
		TSP_H_LOW = 3'h2,
		TSP_H_HIGH = 3'h3,
		TSP_H_GAP = 3'h4,
		TSP_H_WAIT = 3'h5,
		TSP_H_LAG = 3'h6,
		TSP_H_SPACE = 3'h7
	} tsp_host_state_t;
	typedef logic [7:0] tsp_cmd_t;
	typedef logic [15:0] tsp_result_t;
endpackage

/* rtl/tsp_link_if.sv */
// Serial link between the host master and the touch converter port.
// The data-out line is modelled with a weak pull-up when not driven.
`timescale 1ns/10ps
`default_nettype none
interface tsp_link_if;
	logic sclk;
	logic cs_n;
	logic serial_in;
	logic serial_out;
	logic serial_out_oe;
	logic serial_out_line;
	logic pen_touch_irq_n;

	assign serial_out_line = serial_out_oe ? serial_out : 1'b1;

	modport dev (
		input sclk, cs_n, serial_in,
		output serial_out, serial_out_oe, pen_touch_irq_n
	);
	modport host (
		output sclk, cs_n, serial_in,
		input serial_out_line, pen_touch_irq_n
	);
endinterface
`default_nettype wire

/* rtl/tsp_device.sv */
// Device end of the touch converter serial port: SPI mode-0 slave with
// command capture, result shift-out and the pen touch / busy line.
// Assumes the converter core hands over results and a done pulse on sys_clk_i.
//
// Summary of operation
// [RQ1] Mode 0: clock idles low, rising samples.
// [RQ2] Output bit changes only on clock falls.
// [RQ3] Input bit captured on each clock rise.
// [RQ4] Command byte is exactly eight clocks.
// [RQ5] Eight or sixteen read clocks follow command.
// [RQ6] Long frame 24 clocks, short frame 16.
// [RQ7] Interrupt line low while panel is touched.
// [RQ8] Stays low until conversion done or release.
// [RQ9] Rising interrupt edge marks conversion end.
// [RQ10] Busy low after rise; host waits high.
// [RQ11] Output driven only while selected.
// [RQ12] Host makes the clock; device never drives.
// [RQ13] Received byte loads the command register.
// [RQ14] Select high clears the bit counter.
`timescale 1ns/10ps
`default_nettype none
`include "tsp_defs.svh"
module tsp_device (
	input wire logic sys_clk_i,
	input wire logic reset_i,
	tsp_link_if.dev link,
	input wire tsp_pkg::tsp_result_t result_i,
	input wire logic result_16_i,
	input wire logic touch_i,
	input wire logic conv_done_i,
	output logic [7:0] command_o,
	output logic command_valid_o
);
	import tsp_pkg::*;

	// ------------------------------------------------------------------------
	// Pin synchronisers
	// ------------------------------------------------------------------------
	logic [2:0] cs_sync, sclk_sync, sdi_sync;
	logic cs_f, sclk_f, sdi_f;
	logic [2:0] next_cs_sync, next_sclk_sync, next_sdi_sync;
	logic next_cs_f, next_sclk_f, next_sdi_f;

	// The first stage may go metastable; only the last two vote
	// A level counts only once the second and third stages agree
	function automatic logic settle(input logic [2:0] s, input logic prev);
		return (s[1] == s[2]) ? s[1] : prev;
	endfunction

	always_comb begin
		next_cs_sync = {cs_sync[1:0], link.cs_n};
		next_sclk_sync = {sclk_sync[1:0], link.sclk}; // RQ12
		next_sdi_sync = {sdi_sync[1:0], link.serial_in};
		next_cs_f = settle(cs_sync, cs_f);
		next_sclk_f = settle(sclk_sync, sclk_f);
		next_sdi_f = settle(sdi_sync, sdi_f);
	end

	always_ff @(posedge sys_clk_i) begin
		if (reset_i) begin
			cs_sync <= `TSP_SYNC_HIGH;
			sclk_sync <= `TSP_SYNC_LOW;
			sdi_sync <= `TSP_SYNC_LOW;
			cs_f <= 1'b1;
			sclk_f <= 1'b0;
			sdi_f <= 1'b0;
		end else begin
			cs_sync <= next_cs_sync;
			sclk_sync <= next_sclk_sync;
			sdi_sync <= next_sdi_sync;
			cs_f <= next_cs_f;
			sclk_f <= next_sclk_f;
			sdi_f <= next_sdi_f;
		end
	end

	// ------------------------------------------------------------------------
	// Serial shifter
	// ------------------------------------------------------------------------
	logic sclk_rise, sclk_fall, selected;
	logic [4:0] bit_cnt, next_bit_cnt, frame_end;
	logic [7:0] rx, next_rx;
	tsp_result_t tx, next_tx;
	logic len16, next_len16;
	logic out_bit, next_out_bit, out_oe, next_out_oe;
	tsp_cmd_t command, next_command;
	logic cmd_valid, next_cmd_valid;

	// The shifter and the command capture append a bit the same way
	function automatic tsp_cmd_t shift_in(input tsp_cmd_t word, input logic bit_in);
		return {word[6:0], bit_in};
	endfunction

	// Half periods under about five system clocks outrun the synchronisers
	// Clock idles low, so edges are judged against the settled level
	assign sclk_rise = next_sclk_f & ~sclk_f; // RQ1
	assign sclk_fall = ~next_sclk_f & sclk_f;
	assign selected = ~next_cs_f;
	// Read length latches with the command, so result_16_i may change mid-frame
	assign frame_end = len16 ? `TSP_RD16_END : `TSP_RD8_END; // RQ5 RQ6

	always_comb begin
		next_bit_cnt = bit_cnt;
		next_rx = rx;
		next_tx = tx;
		next_len16 = len16;
		next_out_bit = out_bit;
		next_command = command;
		next_cmd_valid = 1'b0;
		// Enable follows the settled select, so the line floats soon after release
		next_out_oe = selected; // RQ11
		if (!selected) begin
			next_bit_cnt = `TSP_CNT_ZERO; // RQ14
			next_out_bit = 1'b0;
		end else if (sclk_rise) begin
			next_rx = shift_in(rx, sdi_f); // RQ3
			// A finished read lets the next byte start a new command
			if (bit_cnt == frame_end) begin
				next_bit_cnt = `TSP_CNT_ONE;
			end else begin
				next_bit_cnt = bit_cnt + `TSP_CNT_ONE;
			end
			if (next_bit_cnt == `TSP_CMD_BITS) begin // RQ4
				next_command = shift_in(rx, sdi_f); // RQ13
				next_cmd_valid = 1'b1;
				next_len16 = result_16_i;
				next_tx = result_16_i ? result_i : {result_i[7:0], `TSP_RD8_PAD};
			end
		end else if (sclk_fall) begin
			// Data leaves on the fall after the eighth rise, MSB first
			if (bit_cnt >= `TSP_CMD_BITS && bit_cnt < frame_end) begin
				next_out_bit = tx[15]; // RQ2
				next_tx = {tx[14:0], 1'b0};
			end else begin
				next_out_bit = 1'b0; // RQ2
			end
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (reset_i) begin
			bit_cnt <= `TSP_CNT_ZERO;
			rx <= `TSP_CMD_CLEAR;
			tx <= `TSP_RES_CLEAR;
			len16 <= 1'b0;
			out_bit <= 1'b0;
			out_oe <= 1'b0;
			command <= `TSP_CMD_CLEAR;
			cmd_valid <= 1'b0;
		end else begin
			bit_cnt <= next_bit_cnt;
			rx <= next_rx;
			tx <= next_tx;
			len16 <= next_len16;
			out_bit <= next_out_bit;
			out_oe <= next_out_oe;
			command <= next_command;
			cmd_valid <= next_cmd_valid;
		end
	end

	// ------------------------------------------------------------------------
	// Link and command outputs
	// ------------------------------------------------------------------------
	assign link.serial_out = out_bit;
	assign link.serial_out_oe = out_oe;
	assign command_o = command;
	assign command_valid_o = cmd_valid;

	// ------------------------------------------------------------------------
	// Pen touch / busy line
	// ------------------------------------------------------------------------
	logic busy, next_busy, eoc, next_eoc, irq_n, next_irq_n;

	always_comb begin
		next_busy = busy;
		next_eoc = eoc;
		if (conv_done_i) begin
			next_busy = 1'b0; // RQ8
		end
		// A command in the same cycle as a done pulse still counts
		if (cmd_valid) begin
			next_busy = 1'b1; // RQ10
		end
		if (!touch_i || cmd_valid) begin
			next_eoc = 1'b0;
		end
		if (conv_done_i) begin
			next_eoc = 1'b1; // RQ9
		end
		// A held touch with no conversion keeps it low, so a waiting host stalls
		// Conversion running, or untouched-by-result touch, pulls it low
		next_irq_n = ~(next_busy | (touch_i & ~next_eoc)); // RQ7 RQ8 RQ9 RQ10
	end

	always_ff @(posedge sys_clk_i) begin
		if (reset_i) begin
			busy <= 1'b0;
			eoc <= 1'b0;
			irq_n <= 1'b1;
		end else begin
			busy <= next_busy;
			eoc <= next_eoc;
			irq_n <= next_irq_n;
		end
	end

	assign link.pen_touch_irq_n = irq_n;
endmodule
`default_nettype wire

/* rtl/tsp_host.sv */
// Host end of the touch converter serial port: SPI mode-0 master that sends
// one command byte and reads back 8 or 16 result bits.
// Assumes the device answers on the tsp_link_if link; clock made by divider.
`timescale 1ns/10ps
`default_nettype none
`include "tsp_defs.svh"
module tsp_host (
	input wire logic sys_clk_i,
	input wire logic reset_i,
	tsp_link_if.host link,
	input wire logic start_i,
	input wire tsp_pkg::tsp_cmd_t command_i,
	input wire logic read16_i,
	output logic ready_o,
	output tsp_pkg::tsp_result_t result_o,
	output logic result_valid_o
);
	import tsp_pkg::*;

	// ------------------------------------------------------------------------
	// Pin synchronisers
	// ------------------------------------------------------------------------
	logic [2:0] sdo_sync, irq_sync, next_sdo_sync, next_irq_sync;
	logic sdo_f, irq_f, next_sdo_f, next_irq_f;

	function automatic logic settle(input logic [2:0] s, input logic prev);
		return (s[1] == s[2]) ? s[1] : prev;
	endfunction

	always_comb begin
		next_sdo_sync = {sdo_sync[1:0], link.serial_out_line};
		next_irq_sync = {irq_sync[1:0], link.pen_touch_irq_n};
		next_sdo_f = settle(sdo_sync, sdo_f);
		next_irq_f = settle(irq_sync, irq_f);
	end

	always_ff @(posedge sys_clk_i) begin
		if (reset_i) begin
			sdo_sync <= `TSP_SYNC_HIGH;
			irq_sync <= `TSP_SYNC_HIGH;
			sdo_f <= 1'b1;
			irq_f <= 1'b1;
		end else begin
			sdo_sync <= next_sdo_sync;
			irq_sync <= next_irq_sync;
			sdo_f <= next_sdo_f;
			irq_f <= next_irq_f;
		end
	end

	// ------------------------------------------------------------------------
	// Transfer sequencer
	// ------------------------------------------------------------------------
	tsp_host_state_t state, next_state;
	logic [4:0] cnt, next_cnt, bit_n, next_bit_n, total, next_total;
	tsp_cmd_t tx, next_tx;
	tsp_result_t rx, next_rx, res, next_res;
	logic sclk, next_sclk, cs_n, next_cs_n, mosi, next_mosi;
	logic res_valid, next_res_valid;

	always_comb begin
		next_state = state;
		next_cnt = cnt + `TSP_CNT_ONE;
		next_bit_n = bit_n;
		next_total = total;
		next_tx = tx;
		next_rx = rx;
		next_res = res;
		next_sclk = sclk;
		next_cs_n = cs_n;
		next_mosi = mosi;
		next_res_valid = 1'b0;
		unique case (state)
			TSP_H_IDLE: begin
				next_cnt = `TSP_CNT_ZERO;
				if (start_i) begin
					next_tx = command_i;
					next_total = read16_i ? `TSP_RD16_END : `TSP_RD8_END;
					next_bit_n = `TSP_CNT_ZERO;
					next_cs_n = 1'b0;
					next_mosi = command_i[7];
					next_state = TSP_H_LEAD;
				end
			end
			TSP_H_LEAD: begin
				if (cnt == `TSP_LEAD_CYC) begin
					next_cnt = `TSP_CNT_ZERO;
					next_state = TSP_H_LOW;
				end
			end
			TSP_H_LOW: begin
				if (cnt == `TSP_HALF_CYC - `TSP_CNT_ONE) begin
					next_cnt = `TSP_CNT_ZERO;
					next_sclk = 1'b1; // RQ1 RQ12
					next_state = TSP_H_HIGH;
				end
			end
			TSP_H_HIGH: begin
				if (cnt == `TSP_HALF_CYC - `TSP_CNT_ONE) begin
					// Sample late in the high phase to cover both sync delays
					if (bit_n >= `TSP_CMD_BITS) begin
						next_rx = {rx[14:0], sdo_f};
					end
					next_cnt = `TSP_CNT_ZERO;
					next_sclk = 1'b0;
					next_bit_n = bit_n + `TSP_CNT_ONE;
					next_tx = {tx[6:0], 1'b0};
					next_mosi = tx[6];
					if (next_bit_n == total) begin // RQ6
						next_state = TSP_H_LAG;
					end else if (next_bit_n == `TSP_CMD_BITS) begin // RQ4
						next_state = TSP_H_GAP;
					end else begin
						next_state = TSP_H_LOW;
					end
				end
			end
			TSP_H_GAP: begin
				// Leaves room for the busy fall to reach this side
				if (cnt == `TSP_BUSY_GAP_CYC) begin
					next_state = TSP_H_WAIT;
				end
			end
			TSP_H_WAIT: begin
				next_cnt = `TSP_CNT_ZERO;
				if (irq_f) begin
					next_state = TSP_H_LOW; // RQ10
				end
			end
			TSP_H_LAG: begin
				if (cnt == `TSP_LAG_CYC) begin
					next_cnt = `TSP_CNT_ZERO;
					next_cs_n = 1'b1;
					next_mosi = 1'b0;
					next_res = (total == `TSP_RD16_END) ? rx : {`TSP_RD8_PAD, rx[7:0]}; // RQ5
					next_res_valid = 1'b1;
					next_state = TSP_H_SPACE;
				end
			end
			TSP_H_SPACE: begin
				if (cnt == `TSP_SPACE_CYC) begin
					next_state = TSP_H_IDLE;
				end
			end
		endcase
	end

	always_ff @(posedge sys_clk_i) begin
		if (reset_i) begin
			state <= TSP_H_IDLE;
			cnt <= `TSP_CNT_ZERO;
			bit_n <= `TSP_CNT_ZERO;
			total <= `TSP_RD8_END;
			tx <= `TSP_CMD_CLEAR;
			rx <= `TSP_RES_CLEAR;
			res <= `TSP_RES_CLEAR;
			sclk <= 1'b0;
			cs_n <= 1'b1;
			mosi <= 1'b0;
			res_valid <= 1'b0;
			ready_o <= 1'b0;
		end else begin
			state <= next_state;
			cnt <= next_cnt;
			bit_n <= next_bit_n;
			total <= next_total;
			tx <= next_tx;
			rx <= next_rx;
			res <= next_res;
			sclk <= next_sclk;
			cs_n <= next_cs_n;
			mosi <= next_mosi;
			res_valid <= next_res_valid;
			ready_o <= (next_state == TSP_H_IDLE);
		end
	end

	assign link.sclk = sclk;
	assign link.cs_n = cs_n;
	assign link.serial_in = mosi;
	assign result_o = res;
	assign result_valid_o = res_valid;
endmodule
`default_nettype wire

/* test/tsp_link_asserts.sv */
// Checker for the touch converter serial link between host and device ends.
// Assumes it sits beside the link interface and sees its signals as plain inputs.
`timescale 1ns/10ps
`default_nettype none
module tsp_link_asserts (
	input wire logic sys_clk_i,
	input wire logic reset_i,
	input wire logic sclk,
	input wire logic cs_n,
	input wire logic serial_in,
	input wire logic serial_out,
	input wire logic serial_out_oe,
	input wire logic serial_out_line,
	input wire logic pen_touch_irq_n
);
	default clocking cb @(posedge sys_clk_i);
	endclocking
	default disable iff (reset_i);
	// --------------------------------
	// Edge bookkeeping
	// --------------------------------
	logic sclk_q;
	logic next_sclk_q;
	logic [4:0] rises;
	logic [4:0] next_rises;
	logic [3:0] since_fall;
	logic [3:0] next_since_fall;
	always_comb begin
		next_sclk_q = reset_i ? 1'b0 : sclk;
		next_rises = (reset_i || cs_n) ? 5'h00 : rises + 5'(sclk & ~sclk_q);
		// Saturates so a long idle never wraps into a false recent fall
		next_since_fall = reset_i ? 4'hF : (!sclk && sclk_q) ? 4'h0
			: since_fall + 4'(since_fall != 4'hF);
	end
	always_ff @(posedge sys_clk_i) begin
		sclk_q <= next_sclk_q;
		rises <= next_rises;
		since_fall <= next_since_fall;
	end
	// --------------------------------
	// Link properties
	// --------------------------------
	a_clk_idle_low: assert property (cs_n |-> !sclk)
		else $error("serial clock high while deselected");
	a_lead_low: assert property ($fell(cs_n) |-> !sclk [*3])
		else $error("serial clock rose too soon after select");
	a_in_steady_high: assert property (sclk |-> $stable(serial_in))
		else $error("serial input moved while clock high");
	a_out_after_fall: assert property ($changed(serial_out) && serial_out_oe && $past(serial_out_oe)
		|-> since_fall <= 4'h8)
		else $error("serial output moved away from a clock fall");
	a_oe_off_idle: assert property (cs_n [*7] |-> !serial_out_oe && serial_out_line)
		else $error("serial output driven while deselected");
	a_frame_len: assert property ($rose(cs_n) |-> rises == 5'd16 || rises == 5'd24)
		else $error("frame length not 16 or 24 clocks");
	a_busy_falls: assert property ($rose(sclk) && rises == 5'd7 |-> ##[1:12] !pen_touch_irq_n)
		else $error("busy not shown after command byte");
	a_read_gated: assert property ($rose(sclk) && rises == 5'd8 |-> pen_touch_irq_n)
		else $error("read clock issued while busy");
endmodule
`default_nettype wire

/* test/tb_top.sv */
// Self-checking bench: host and device ends joined by the link interface.
// Assumes the design files compile first; random values from a fixed start.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
	import tsp_pkg::*;
	logic sys_clk_i = 1'b0;
	logic reset_i = 1'b1;
	logic host_rst = 1'b0;
	logic start_i = 1'b0;
	logic read16_i = 1'b0;
	logic result_16_i = 1'b0;
	logic touch_i = 1'b0;
	logic conv_done_i = 1'b0;
	logic ready_o;
	logic result_valid_o;
	logic command_valid_o;
	tsp_cmd_t command_i = 8'h00;
	tsp_result_t result_i = 16'h0000;
	tsp_result_t result_o;
	logic [7:0] command_o;
	logic [15:0] rnd = 16'h0002;
	logic [23:0] mosi = 24'h000000;
	logic [23:0] miso = 24'h000000;
	int failures = 0;
	int total_checks = 0;
	int sclk_rises = 0;
	int n;
	int k;
	tsp_link_if link();
	tsp_device i_tsp_device(.sys_clk_i, .reset_i, .link(link), .result_i, .result_16_i,
		.touch_i, .conv_done_i, .command_o, .command_valid_o);
	tsp_host i_tsp_host(.sys_clk_i, .reset_i(reset_i | host_rst), .link(link), .start_i,
		.command_i, .read16_i, .ready_o, .result_o, .result_valid_o);
	tsp_link_asserts i_chk(.sys_clk_i, .reset_i(reset_i | host_rst), .sclk(link.sclk),
		.cs_n(link.cs_n),
		.serial_in(link.serial_in), .serial_out(link.serial_out),
		.serial_out_oe(link.serial_out_oe), .serial_out_line(link.serial_out_line),
		.pen_touch_irq_n(link.pen_touch_irq_n));
	// --------------------------------
	// Clock, wire monitor, helpers
	// --------------------------------
	always #4 sys_clk_i = ~sys_clk_i;
	always @(posedge link.sclk) begin
		if (!link.cs_n) begin
			mosi <= {mosi[22:0], link.serial_in};
			miso <= {miso[22:0], link.serial_out_line};
			sclk_rises <= sclk_rises + 1;
		end
	end
	function automatic logic [15:0] lfsr(input logic [15:0] v);
		return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
	endfunction
	function automatic tsp_result_t exp_res(input tsp_result_t r, input logic w);
		return w ? r : {8'h00, r[7:0]};
	endfunction
	task automatic tick(input int c);
		repeat (c) @(posedge sys_clk_i);
		#1;
	endtask
	task automatic chk(input logic [15:0] seen, input logic [15:0] want);
		total_checks++;
		if (seen !== want) begin
			failures++;
			$display("mismatch at %0t: saw %h expected %h", $time, seen, want);
		end
	endtask
	task automatic results();
		if (failures == 0 && total_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	task automatic launch(input tsp_cmd_t c, input logic w);
		command_i = c;
		read16_i = w;
		for (n = 0; n < 2000 && ready_o !== 1'b1; n++) tick(1);
		chk({15'h0000, ready_o}, 16'h0001);
		start_i = 1'b1;
		tick(1);
		start_i = 1'b0;
	endtask
	task automatic xfer(input tsp_cmd_t c, input tsp_result_t r, input logic w, input logic t);
		int base;
		result_i = r;
		result_16_i = w;
		touch_i = t;
		base = sclk_rises;
		launch(c, w);
		for (n = 0; n < 2000 && command_valid_o !== 1'b1; n++) tick(1);
		chk({15'h0000, command_valid_o}, 16'h0001);
		chk({8'h00, command_o}, {8'h00, c});
		tick(2);
		chk({15'h0000, link.pen_touch_irq_n}, 16'h0000);
		tick(1 + int'(rnd[3:0]));
		conv_done_i = 1'b1;
		tick(1);
		conv_done_i = 1'b0;
		tick(2);
		chk({15'h0000, link.pen_touch_irq_n}, 16'h0001);
		for (n = 0; n < 2000 && result_valid_o !== 1'b1; n++) tick(1);
		chk({15'h0000, result_valid_o}, 16'h0001);
		chk(16'(sclk_rises - base), w ? 16'h0018 : 16'h0010);
		chk(result_o, exp_res(r, w));
		chk({8'h00, w ? mosi[23:16] : mosi[15:8]}, {8'h00, c});
		chk(w ? miso[15:0] : {8'h00, miso[7:0]}, exp_res(r, w));
		tick(6);
		chk({15'h0000, link.serial_out_line}, 16'h0001);
	endtask
	task automatic pen_only();
		touch_i = 1'b0;
		tick(5);
		touch_i = 1'b1;
		tick(5);
		chk({15'h0000, link.pen_touch_irq_n}, 16'h0000);
		touch_i = 1'b0;
		tick(5);
		chk({15'h0000, link.pen_touch_irq_n}, 16'h0001);
	endtask
	// --------------------------------
	// Main sequence and watchdog
	// --------------------------------
	initial begin
		tick(10);
		reset_i = 1'b0;
		tick(2);
		pen_only();
		xfer(8'hFF, 16'hFFFF, 1'b1, 1'b1);
		xfer(8'h00, 16'h0000, 1'b0, 1'b0);
		xfer(8'h80, 16'h8001, 1'b0, 1'b1);
		for (k = 0; k < 16; k++) begin
			rnd = lfsr(rnd);
			xfer(rnd[7:0], lfsr(rnd), rnd[8], rnd[9]);
		end
		// Host alone drops select mid-command; the device must start afresh
		launch(8'hC3, 1'b0);
		tick(60);
		host_rst = 1'b1;
		tick(10);
		host_rst = 1'b0;
		tick(2);
		chk({15'h0000, link.cs_n}, 16'h0001);
		xfer(8'h3C, 16'hA55A, 1'b0, 1'b1);
		// Cut a frame short by reset before the command byte completes
		launch(8'hA5, 1'b1);
		tick(60);
		reset_i = 1'b1;
		tick(10);
		reset_i = 1'b0;
		tick(2);
		chk({8'h00, command_o}, 16'h0000);
		chk({15'h0000, link.cs_n}, 16'h0001);
		xfer(8'h5A, 16'h1234, 1'b1, 1'b0);
		pen_only();
		results();
	end
	initial begin
		repeat (60000) @(posedge sys_clk_i);
		failures++;
		results();
	end
endmodule
`default_nettype wire
